//--- inc/utx_baud_if.sv
/*
 * Carrier between the transmit controller and its baud tick generator.
 * Assumes both ends share clk_in.
 */
interface utx_baud_if;
    logic [15:0] int_div;
    logic [5:0]  frac_div;
    logic        ovs_sel;
    logic        run;
    logic        bit_tick;

    modport gen (input int_div, input frac_div, input ovs_sel, input run, output bit_tick);
    modport ctl (output int_div, output frac_div, output ovs_sel, output run, input bit_tick);
endinterface

//--- inc/utx_pkg.sv
/*
 * Constants and types shared by the transmit baud, break and parity block.
 * Assumes a single clock, a synchronous reset and byte addresses on the register port.
 */
package utx_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam int              UTX_ADDR_W     = 8;
    localparam logic [7:0]      UTX_FRAC_OFF   = 8'h28;
    localparam logic [7:0]      UTX_LINE_OFF   = 8'h2C;
    localparam logic [7:0]      UTX_STAT_OFF   = 8'h34;

    // ************************************************************
    // field layout and reset values
    // ************************************************************
    localparam int              UTX_INT_W      = 16;
    localparam int              UTX_FRAC_W     = 6;
    localparam int              UTX_BRK_BIT    = 0;
    localparam int              UTX_PAR_BIT    = 1;
    localparam int              UTX_EVEN_BIT   = 2;
    localparam int              UTX_ST_BUSY    = 0;
    localparam int              UTX_ST_BRK     = 1;
    localparam int              UTX_ST_PEND    = 2;
    localparam int              UTX_ST_OVS     = 3;
    localparam logic [5:0]      UTX_FRAC_RST   = 6'h00;
    localparam logic [15:0]     UTX_INT_RST    = 16'h0000;
    localparam logic [2:0]      UTX_LINE_RST   = 3'h0;

    // ************************************************************
    // timing counts
    // ************************************************************
    localparam logic [4:0]      UTX_OVS_16     = 5'h10;
    localparam logic [4:0]      UTX_OVS_8      = 5'h08;

    typedef enum logic [2:0] {
        UTX_IDLE,
        UTX_START,
        UTX_DATA,
        UTX_PARITY,
        UTX_STOP,
        UTX_BREAK
    } utx_state_t;
endpackage

//--- test/utx_props.sv
/*
 * Port checker for the transmitter top.
 * Assumes ce_in stays high and the line and fraction registers change only by wr_in.
 */
module utx_props
    import utx_pkg::*;
(
    input wire logic                  clk_in,        // clock
    input wire logic                  rst_in,        // reset
    input wire logic [UTX_ADDR_W-1:0] addr_in,       // address
    input wire logic [31:0]           wdata_in,      // write data
    input wire logic                  wr_in,         // write strobe
    input wire logic                  rd_in,         // read strobe
    input wire logic [31:0]           rdata_out,     // read data
    input wire logic [15:0]           int_div_in,    // integer divisor
    input wire logic                  ovs_sel_in,    // oversample select
    input wire logic                  rx_busy_in,    // receiver busy
    input wire logic [7:0]            fifo_data_in,  // fifo head
    input wire logic                  fifo_valid_in, // fifo valid
    input wire logic                  fifo_pop_out,  // pop
    input wire logic                  tx_out,        // serial line
    input wire logic                  tx_busy_out    // busy
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // shadow of written fields
    // ************************************************************
    logic       brk_q;
    logic [5:0] frac_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            brk_q <= 1'b0;
        end else if (wr_in && addr_in == UTX_LINE_OFF) begin
            brk_q <= wdata_in[UTX_BRK_BIT];
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            frac_q <= 6'h00;
        end else if (wr_in && addr_in == UTX_FRAC_OFF) begin
            frac_q <= wdata_in[5:0];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ************************************************************
    // properties
    // ************************************************************
    property p_rd_idle; !$past(rd_in) |-> rdata_out == 32'h0000_0000; endproperty
    property p_rd_frac; rd_in && addr_in == UTX_FRAC_OFF |=> rdata_out[31:6] == 26'h0; endproperty
    property p_pop_ok;
        fifo_pop_out |-> fifo_valid_in && !rx_busy_in && !tx_busy_out && !brk_q;
    endproperty
    property p_brk_low; brk_q && !tx_busy_out |-> ##2 (!tx_out || !brk_q); endproperty
    property p_brk_rel;
        (brk_q && !tx_out && tx_busy_out) [*8] ##1 !brk_q |-> ##[0:1] tx_out;
    endproperty
    sequence s_div1; int_div_in == 16'h0001 && frac_q == 6'h00 && fifo_data_in[0]; endsequence
    property p_start8; fifo_pop_out && ovs_sel_in ##0 s_div1 |=> !tx_out [*8] ##1 tx_out; endproperty
    property p_start16;
        fifo_pop_out && !ovs_sel_in ##0 s_div1 |-> ##16 !tx_out ##1 tx_out;
    endproperty
    property p_idle_hi; !tx_busy_out && !$past(tx_busy_out) |-> tx_out; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    a_rd_frac: assert property (p_rd_frac) else $error("fraction upper bits set");
    a_pop_ok: assert property (p_pop_ok) else $error("pop when not allowed");
    a_brk_low: assert property (p_brk_low) else $error("break not driven low");
    a_brk_rel: assert property (p_brk_rel) else $error("line not high after break");
    a_start8: assert property (p_start8) else $error("start bit not 8 clocks");
    a_start16: assert property (p_start16) else $error("start bit not 16 clocks");
    a_idle_hi: assert property (p_idle_hi) else $error("idle line low");
    c_pop: cover property (fifo_pop_out);
    c_brk: cover property (brk_q && !tx_out);
    c_rd: cover property (rd_in && addr_in == UTX_STAT_OFF);
endmodule

//--- test/utx_rx_model.sv
/*
 * Remote receiver: finds a falling edge after idle and samples each bit mid period.
 * Assumes the bench sets period and parity before the frame starts.
 */
module utx_rx_model (
    input  wire logic       clk_in,    // clock
    input  wire logic       tx_in,     // serial line
    input  int              period_in, // clocks per bit
    input  wire logic       par_in,    // parity expected
    output logic      [7:0] data_out,  // last byte
    output logic            par_out,   // last parity bit
    output logic            stop_out,  // last stop bit
    output int              n_out      // frames seen
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        n_out = 0;
        data_out = 8'h00;
        par_out = 1'b0;
        stop_out = 1'b1;
        forever begin
            // a break ends only when the line goes high again
            @(posedge clk_in iff tx_in === 1'b1);
            @(posedge clk_in iff tx_in === 1'b0);
            repeat (period_in / 2) @(posedge clk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (period_in) @(posedge clk_in);
                data_out[i] = tx_in;
            end
            if (par_in) begin
                repeat (period_in) @(posedge clk_in);
                par_out = tx_in;
            end
            repeat (period_in) @(posedge clk_in);
            stop_out = tx_in;
            n_out++;
        end
    end
endmodule

//--- test/utx_top_tb_top.sv
/*
 * Bench for the transmitter: register tasks, FIFO feed, receiver model.
 * Assumes ce_in held high and 8 data bits.
 */
module utx_top_tb_top
    import utx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic        ovs_sel_in = 1'b1;
    logic        rx_busy_in = 1'b0;
    logic        fifo_valid_in = 1'b0;
    logic        par_on = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [7:0]  fifo_data_in = 8'h00;
    logic [15:0] int_div_in = 16'h0001;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic [31:0] rdata_out;
    logic [31:0] rv;
    logic [7:0]  rx_data;
    logic        rx_par;
    logic        rx_stop;
    logic        fifo_pop_out;
    logic        tx_out;
    logic        tx_busy_out;
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          pops = 0;
    int          per = 8;
    int          n_rx;
    utx_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .int_div_in(int_div_in), .ovs_sel_in(ovs_sel_in), .rx_busy_in(rx_busy_in),
        .fifo_data_in(fifo_data_in), .fifo_valid_in(fifo_valid_in),
        .fifo_pop_out(fifo_pop_out), .tx_out(tx_out), .tx_busy_out(tx_busy_out));
    utx_rx_model rx_u (.clk_in(clk_in), .tx_in(tx_out), .period_in(per), .par_in(par_on),
        .data_out(rx_data), .par_out(rx_par), .stop_out(rx_stop), .n_out(n_rx));
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (fifo_pop_out === 1'b1) begin
            pops++;
        end
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic stop_test();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(posedge clk_in);
        d = rdata_out;
    endtask
    task automatic push(input logic [7:0] b);
        int t;
        t = 0;
        @(posedge clk_in);
        fifo_data_in <= b;
        fifo_valid_in <= 1'b1;
        do begin
            @(posedge clk_in);
            t++;
        end while (fifo_pop_out !== 1'b1 && t < 400);
        fifo_valid_in <= 1'b0;
        chk("pop", 32'h1, {31'h0, fifo_pop_out});
    endtask
    task automatic recv(input logic [7:0] b, input logic p);
        int n;
        int t;
        n = n_rx;
        t = 0;
        while (n_rx == n && t < per * 14) begin
            @(posedge clk_in);
            t++;
        end
        chk("rx frames", 32'(n + 1), 32'(n_rx));
        chk("rx data", {24'h0, b}, {24'h0, rx_data});
        if (par_on) begin
            chk("rx parity", {31'h0, p}, {31'h0, rx_par});
        end
        chk("rx stop", 32'h1, {31'h0, rx_stop});
    endtask
    task automatic blocked(input logic [7:0] b);
        int p0;
        p0 = pops;
        @(posedge clk_in);
        fifo_data_in <= b;
        fifo_valid_in <= 1'b1;
        repeat (150) @(posedge clk_in);
        fifo_valid_in <= 1'b0;
        chk("pops while blocked", p0, pops);
    endtask
    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(UTX_FRAC_OFF, rv);
        chk("fraction reset", 32'h0, rv);
        rd(UTX_LINE_OFF, rv);
        chk("line reset", 32'h0, rv);
        rd(8'h30, rv);
        chk("unmapped", 32'h0, rv);
        wr(UTX_FRAC_OFF, 32'hFFFF_FFFF);
        rd(UTX_FRAC_OFF, rv);
        chk("fraction rw", 32'h3F, rv);
        wr(UTX_FRAC_OFF, 32'h0);
        for (int k = 0; k < 4; k++) begin
            ovs_sel_in <= (k != 1);
            int_div_in <= (k == 2) ? 16'h0002 : 16'h0001;
            per = (k == 0) ? 8 : ((k == 3) ? 12 : 16);
            if (k == 3) begin
                wr(UTX_FRAC_OFF, 32'h20);
            end
            push(8'h35);
            recv(8'h35, 1'b0);
        end
        wr(UTX_FRAC_OFF, 32'h0);
        per = 8;
        for (int m = 0; m < 8; m++) begin
            logic [7:0] b;
            b = m[0] ? 8'hA5 : 8'h07;
            wr(UTX_LINE_OFF, {29'h0, m[2:1], 1'b0});
            par_on = m[1];
            push(b);
            recv(b, m[2] ? ^b : ~^b);
        end
        wr(UTX_LINE_OFF, 32'h0);
        par_on = 1'b0;
        push(8'h5A);
        int_div_in <= 16'h0003;
        recv(8'h5A, 1'b0);
        per = 24;
        push(8'hC3);
        recv(8'hC3, 1'b0);
        int_div_in <= 16'h0001;
        per = 8;
        rx_busy_in <= 1'b1;
        blocked(8'h99);
        rd(UTX_STAT_OFF, rv);
        chk("update pending", 32'h1, {31'h0, rv[UTX_ST_PEND]});
        rx_busy_in <= 1'b0;
        push(8'h99);
        recv(8'h99, 1'b0);
        wr(UTX_LINE_OFF, 32'h1);
        blocked(8'h66);
        chk("line in break", 32'h0, {31'h0, tx_out});
        chk("busy in break", 32'h1, {31'h0, tx_busy_out});
        chk("break stop", 32'h0, {31'h0, rx_stop});
        rd(UTX_STAT_OFF, rv);
        chk("break active", 32'h1, {31'h0, rv[UTX_ST_BRK]});
        wr(UTX_LINE_OFF, 32'h0);
        push(8'h66);
        recv(8'h66, 1'b0);
        stop_test();
    end
endmodule
bind utx_top utx_props chk_u (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .int_div_in(int_div_in), .ovs_sel_in(ovs_sel_in), .rx_busy_in(rx_busy_in),
    .fifo_data_in(fifo_data_in), .fifo_valid_in(fifo_valid_in),
    .fifo_pop_out(fifo_pop_out), .tx_out(tx_out), .tx_busy_out(tx_busy_out));

//--- verilog/utx_baud_gen.sv
/*
 * Fractional baud divider: one bit tick per 16 or 8 divided clocks.
 * Assumes run is held high for the whole character and the divisor is stable meanwhile.
 */
module utx_baud_gen
    import utx_pkg::*;
(
    input  wire logic clk_in,     // block clock
    input  wire logic rst_in,     // synchronous reset, high
    input  wire logic ce_in,      // clock enable
    utx_baud_if.gen   baud        // divisor in, tick out
);
    logic [15:0] cnt_q;
    logic [5:0]  acc_q;
    logic [4:0]  os_q;
    logic [6:0]  acc_sum;
    logic [15:0] reload;
    logic        os_tick;
    logic [4:0]  os_len;

    assign acc_sum = {1'b0, acc_q} + {1'b0, baud.frac_div};
    // a zero integer part runs as one clock per step
    assign reload  = ((baud.int_div == 16'h0000) ? 16'h0001 : baud.int_div)
                     - 16'h0001 + {15'h0000, acc_sum[6]};
    assign os_tick = baud.run && (cnt_q == 16'h0000);
    assign os_len  = baud.ovs_sel ? UTX_OVS_8 : UTX_OVS_16;

    // ************************************************************
    // divided clock with fractional carry
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_q <= 16'h0000;
            acc_q <= 6'h00;
        end else if (ce_in) begin
            if (!baud.run) begin
                cnt_q <= reload;
                acc_q <= 6'h00;
            end else if (os_tick) begin
                cnt_q <= reload;
                acc_q <= acc_sum[5:0];
            end else begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end

    // ************************************************************
    // oversample count to bit tick
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            os_q <= 5'h00;
        end else if (ce_in) begin
            if (!baud.run) begin
                os_q <= 5'h00;
            end else if (os_tick) begin
                os_q <= (os_q == os_len - 5'h01) ? 5'h00 : os_q + 5'h01;
            end
        end
    end

    assign baud.bit_tick = os_tick && (os_q == os_len - 5'h01);
endmodule

//--- verilog/utx_top.sv
/*
 * Transmitter core: fractional baud divisor with deferred update, send break,
 * and parity generation for outgoing frames, with 1 start and 1 stop bit.
 * Assumes the integer divisor and oversample select come from registers elsewhere,
 * the FIFO presents data with valid and takes a pop, and rx_busy_in is same-clock logic.
 */
import utx_pkg::*;

//
// Contract
// - divisor is 16-bit integer plus 6-bit fraction, both reset to zero.
// - oversample select clear gives divisor of clock over sixteen times baud.
// - oversample select set gives divisor of clock over eight times baud.
// - new divisor values apply only after the current character completes.
// - send break holds line low continuously after the current character.
// - FIFO contents stay untouched while break is driven.
// - parity bit added only when enabled; odd/even ignored otherwise.
// - odd select makes data plus parity hold an odd count of ones.
// - even select makes data plus parity hold an even count of ones.
// - bit period is 16 divided clocks when select clear, 8 when set.
module utx_top
    import utx_pkg::*;
#(
    parameter int DATA_BITS = 8
)(
    input  wire logic                  clk_in,          // block clock, 20 MHz
    input  wire logic                  rst_in,          // synchronous reset, high
    input  wire logic                  ce_in,           // clock enable, freezes state
    input  wire logic [UTX_ADDR_W-1:0] addr_in,         // register byte address
    input  wire logic [31:0]           wdata_in,        // register write data
    input  wire logic                  wr_in,           // write strobe
    input  wire logic                  rd_in,           // read strobe
    output logic      [31:0]           rdata_out,       // read data, cycle after rd_in
    input  wire logic [15:0]           int_div_in,      // integer divisor register value
    input  wire logic                  ovs_sel_in,      // oversample select
    input  wire logic                  rx_busy_in,      // receiver mid-character
    input  wire logic [7:0]            fifo_data_in,    // head of transmit FIFO
    input  wire logic                  fifo_valid_in,   // FIFO holds a character
    output logic                       fifo_pop_out,    // take head of FIFO
    output logic                       tx_out,          // serial line, idle high
    output logic                       tx_busy_out      // character or break in progress
);
    // ************************************************************
    // parameter check
    // ************************************************************
    if (DATA_BITS < 5 || DATA_BITS > 8) begin : g_bad_width
        $error("utx_top: DATA_BITS must be 5 to 8");
    end

    // ************************************************************
    // declarations
    // ************************************************************
    utx_baud_if  baud ();
    utx_state_t  state_q;
    utx_state_t  state_d;
    logic [5:0]  frac_q;
    logic [2:0]  line_q;
    logic [15:0] int_act_q;
    logic [5:0]  frac_act_q;
    logic        ovs_act_q;
    logic [7:0]  shift_q;
    logic [2:0]  bit_q;
    logic        par_q;
    logic        tx_q;
    logic [31:0] rdata_q;
    logic        pend;
    logic        can_load;
    logic        send_break;
    logic        par_on;
    logic        even_sel;
    logic        tick;
    logic        start_char;
    logic        line_d;

    assign send_break      = line_q[UTX_BRK_BIT];
    assign par_on   = line_q[UTX_PAR_BIT];
    assign even_sel = line_q[UTX_EVEN_BIT];
    assign tick     = baud.bit_tick;

    // ************************************************************
    // register writes
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            frac_q <= UTX_FRAC_RST;
            line_q <= UTX_LINE_RST;
        end else if (ce_in && wr_in) begin
            if (addr_in == UTX_FRAC_OFF) begin
                frac_q <= wdata_in[UTX_FRAC_W-1:0];
            end
            if (addr_in == UTX_LINE_OFF) begin
                line_q <= wdata_in[2:0];
            end
        end
    end

    // ************************************************************
    // register reads
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (ce_in) begin
            rdata_q <= 32'h0000_0000;
            if (rd_in) begin
                case (addr_in)
                    UTX_FRAC_OFF: rdata_q <= {26'h000_0000, frac_q};
                    UTX_LINE_OFF: rdata_q <= {29'h0000_0000, line_q};
                    UTX_STAT_OFF: rdata_q <= {28'h000_0000, ovs_act_q, pend,
                                              state_q == UTX_BREAK, tx_busy_out};
                    default:      rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign rdata_out = rdata_q;

    // ************************************************************
    // deferred divisor update
    // ************************************************************
    assign pend     = (int_act_q != int_div_in) || (frac_act_q != frac_q)
                      || (ovs_act_q != ovs_sel_in);
    assign can_load = (state_q == UTX_IDLE) && !rx_busy_in;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            int_act_q  <= UTX_INT_RST;
            frac_act_q <= UTX_FRAC_RST;
            ovs_act_q  <= 1'b0;
        end else if (ce_in && can_load) begin
            int_act_q  <= int_div_in;
            frac_act_q <= frac_q;
            ovs_act_q  <= ovs_sel_in;
        end
    end

    assign baud.int_div  = int_act_q;
    assign baud.frac_div = frac_act_q;
    assign baud.ovs_sel  = ovs_act_q;
    assign baud.run      = (state_q != UTX_IDLE) && (state_q != UTX_BREAK);

    utx_baud_gen u_baud (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .ce_in  (ce_in),
        .baud   (baud)
    );

    // ************************************************************
    // frame sequencer
    // ************************************************************
    // break waits for idle, so it never cuts a character short
    // a pending divisor loads first, so no step of the new character runs on the old one
    assign start_char = (state_q == UTX_IDLE) && !send_break && fifo_valid_in && !rx_busy_in
                        && !pend;

    always_comb begin
        state_d = state_q;
        case (state_q)
            UTX_IDLE: begin
                if (send_break) begin
                    state_d = UTX_BREAK;
                end else if (start_char) begin
                    state_d = UTX_START;
                end
            end
            UTX_START: begin
                if (tick) begin
                    state_d = UTX_DATA;
                end
            end
            UTX_DATA: begin
                if (tick && bit_q == 3'(DATA_BITS - 1)) begin
                    state_d = par_on ? UTX_PARITY : UTX_STOP;
                end
            end
            UTX_PARITY: begin
                if (tick) begin
                    state_d = UTX_STOP;
                end
            end
            UTX_STOP: begin
                if (tick) begin
                    state_d = UTX_IDLE;
                end
            end
            UTX_BREAK: begin
                if (!send_break) begin
                    state_d = UTX_IDLE;
                end
            end
            default: begin
                state_d = UTX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= UTX_IDLE;
        end else if (ce_in) begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // data shifter and parity
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            shift_q <= 8'h00;
            bit_q   <= 3'h0;
            par_q   <= 1'b0;
        end else if (ce_in) begin
            if (start_char) begin
                shift_q <= fifo_data_in;
                bit_q   <= 3'h0;
                // odd: ones plus parity odd; even: ones plus parity even
                par_q   <= (^fifo_data_in[DATA_BITS-1:0]) ^ ~even_sel;
            end else if (state_q == UTX_DATA && tick) begin
                shift_q <= {1'b0, shift_q[7:1]};
                bit_q   <= bit_q + 3'h1;
            end
        end
    end

    // FIFO is popped only when a character starts, never during break
    assign fifo_pop_out = ce_in && start_char;

    // ************************************************************
    // serial line
    // ************************************************************
    always_comb begin
        line_d = 1'b1;
        case (state_d)
            UTX_IDLE:   line_d = 1'b1;
            UTX_START:  line_d = 1'b0;
            UTX_DATA:   line_d = (state_q == UTX_START) ? shift_q[0]
                                 : (tick ? shift_q[1] : shift_q[0]);
            UTX_PARITY: line_d = par_q;
            UTX_STOP:   line_d = 1'b1;
            UTX_BREAK:  line_d = 1'b0;
            default:    line_d = 1'b1;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_q <= 1'b1;
        end else if (ce_in) begin
            tx_q <= line_d;
        end
    end

    assign tx_out      = tx_q;
    assign tx_busy_out = (state_q != UTX_IDLE);
endmodule
